// [caw_host_model.sv]
// Host software model that sends periodic arm pulses to the watchdog.
`timescale 1ns/1ns
module caw_host_model (
   input wire logic clk,
   input wire logic run,
   input wire logic [15:0] period,
   output logic arm_pulse
);
   // -----------------------------------------------------------------
   // Arm pulse generator
   // -----------------------------------------------------------------
   logic [15:0] cnt_r;
   // A pulse leaves as soon as run rises and then once per period.
   // It is two cycles wide so the pin synchroniser cannot miss it.
   always @(negedge clk) begin
      if (!run || cnt_r + 16'h0001 >= period) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
      arm_pulse <= run && (cnt_r < 16'h0002);
   end
endmodule : caw_host_model

// [caw_pkg.sv]
// Shared constants for the chassis alarm watchdog.
package caw_pkg;
   // -----------------------------------------------------------------
   // Timing constants
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 50000000;
   // One tick is 50 ms, half the fastest blink period, so that every
   // blink pattern has a whole number of ticks in each half period.
   localparam int TICK_MS = 50;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int HOLDOFF_MS = 150000;
   localparam int HOLDOFF_TICKS = HOLDOFF_MS / TICK_MS;
   localparam int TIMEOUT_MS = 20000;
   localparam int TIMEOUT_TICKS = TIMEOUT_MS / TICK_MS;
   localparam int WARN_MS = 10000;
   localparam int WARN_TICKS = WARN_MS / TICK_MS;
   localparam int OVT_MS = 480000;
   localparam int OVT_TICKS = OVT_MS / TICK_MS;
   // Blink periods in ticks; each half period is half of this.
   localparam int ARMED_MS = 500;
   localparam int ARMED_TICKS = ARMED_MS / TICK_MS;
   localparam int WARNB_MS = 100;
   localparam int WARNB_TICKS = WARNB_MS / TICK_MS;
   localparam int TRIP_MS = 1000;
   localparam int TRIP_TICKS = TRIP_MS / TICK_MS;
   localparam int FLASH_MS = 500;
   localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
   localparam int CNT_W = 16;
   localparam int TEMP_W = 8;
   localparam logic [7:0] OVT_LIMIT_C = 8'h28;
endpackage : caw_pkg

// [caw_sync.sv]
// Two-flop synchroniser bank for pin inputs.
`timescale 1ns/1ns
module caw_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end

   // Registers clear synchronously.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= meta_nxt;
         q <= q_nxt;
      end
   end
endmodule : caw_sync

// [caw_top.sv]
// Chassis alarm supervisor: host watchdog, fans, supplies and clock lock.
`timescale 1ns/1ns

module caw_top #(
   parameter int TICK_CYC = caw_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic arm_pulse,
   input wire logic major_alarm,
   input wire logic alarm_clear_req,
   input wire logic panel_reset_n,
   input wire logic [7:0] temp_c,
   input wire logic cpu_fan_under,
   input wire logic cpu_fan_over,
   input wire logic supply_one_ok,
   input wire logic supply_two_ok,
   input wire logic clock_lock_board,
   input wire logic unlock_open_jumper,
   input wire logic silence_sw,
   output logic host_restart,
   output logic wd_relay,
   output logic module_relay,
   output logic status_led,
   output logic reset_led,
   output logic fan_a_on,
   output logic fan_b_on,
   output logic fan_centre_on,
   output logic temp_led,
   output logic cpu_fan_led,
   output logic supply_one_led,
   output logic supply_two_led,
   output logic ovt_contact,
   output logic unlock_contact,
   output logic unlock_led,
   output logic buzzer
);
   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NS = 20;
   logic [NS-1:0] raw;
   logic [NS-1:0] s;
   // Active-low pins are inverted before the synchroniser, so that its
   // cleared state reads as idle and no false alarm chirps after reset.
   assign raw = {arm_pulse, ~panel_reset_n, temp_c, cpu_fan_under,
      cpu_fan_over, ~supply_one_ok, ~supply_two_ok, ~clock_lock_board,
      unlock_open_jumper, silence_sw, major_alarm, alarm_clear_req, 1'b0};
   caw_sync #(.W(NS)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d(raw),
      .q(s)
   );
   logic arm_s, pnl_n_s, fu_s, fo_s, p1_s, p2_s, lock_s, jmp_s, sil_s;
   logic maj_s, clr_s;
   logic [7:0] temp_s;
   assign arm_s = s[19];
   assign pnl_n_s = ~s[18];
   assign temp_s = s[17:10];
   assign fu_s = s[9];
   assign fo_s = s[8];
   assign p1_s = ~s[7];
   assign p2_s = ~s[6];
   assign lock_s = ~s[5];
   assign jmp_s = s[4];
   assign sil_s = s[3];
   assign maj_s = s[2];
   assign clr_s = s[1];

   // -----------------------------------------------------------------
   // Prescaler and edge detection
   // -----------------------------------------------------------------
   typedef enum {CAW_HOLD, CAW_RUN, CAW_TRIP} caw_state_e;
   caw_state_e st_r, st_nxt;
   logic [31:0] pre_r, pre_nxt;
   logic tick_r, tick_nxt;
   logic arm_d_r, arm_d_nxt, sil_d_r, sil_d_nxt;
   logic [caw_pkg::CNT_W-1:0] wd_r, wd_nxt, ph_r, ph_nxt, fph_r, fph_nxt;
   logic [caw_pkg::CNT_W-1:0] ovt_r, ovt_nxt;
   logic arm_rise, sil_fall;
   assign arm_rise = arm_s & ~arm_d_r;
   assign sil_fall = ~sil_s & sil_d_r;

   // Blink helper: high during the first half of a period.
   function automatic logic blink(input logic [caw_pkg::CNT_W-1:0] ph,
                                  input int per);
      blink = (32'(ph) % per) < (per / 2);
   endfunction : blink

   logic ovt, fan_bad, p1_bad, p2_bad, ovt_alarm, alarm_any;
   logic muted_r, muted_nxt, rled_r, rled_nxt, rst_r, rst_nxt;
   logic led_nxt;
   assign ovt = temp_s > caw_pkg::OVT_LIMIT_C;
   assign fan_bad = fu_s | fo_s;
   assign p1_bad = ~p1_s;
   assign p2_bad = ~p2_s;
   assign ovt_alarm = ovt_r >= 16'(caw_pkg::OVT_TICKS);
   assign alarm_any = ovt_alarm | fan_bad | p1_bad | p2_bad;

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Counting in 50 ms ticks keeps every tick counter at 16 bits; the cycle prescaler is 32 bits.
   always_comb begin
      pre_nxt = pre_r + 32'h1;
      tick_nxt = 1'b0;
      if (pre_r >= 32'(TICK_CYC - 1)) begin
         pre_nxt = 32'h0;
         tick_nxt = 1'b1;
      end
      arm_d_nxt = arm_s;
      sil_d_nxt = sil_s;
      st_nxt = st_r;
      wd_nxt = wd_r;
      ph_nxt = tick_r ? ph_r + 16'h1 : ph_r;
      fph_nxt = tick_r ? fph_r + 16'h1 : fph_r;
      if (fph_r >= 16'(caw_pkg::FLASH_TICKS - 1) && tick_r)
         fph_nxt = 16'h0;
      rst_nxt = 1'b0;
      case (st_r)
         CAW_HOLD: begin
            if (tick_r) wd_nxt = wd_r + 16'h1;
            if (wd_r >= 16'(caw_pkg::HOLDOFF_TICKS)) begin
               st_nxt = CAW_RUN;
               wd_nxt = 16'h0;
            end
         end
         CAW_RUN: begin
            if (tick_r) wd_nxt = wd_r + 16'h1;
            if (arm_rise) begin
               wd_nxt = 16'h0;
            end else if (wd_r >= 16'(caw_pkg::TIMEOUT_TICKS)) begin
               st_nxt = CAW_TRIP;
               ph_nxt = 16'h0;
               rst_nxt = 1'b1;
            end
         end
         CAW_TRIP: begin
            if (arm_rise) begin
               st_nxt = CAW_RUN;
               wd_nxt = 16'h0;
               ph_nxt = 16'h0;
            end
         end
         default: st_nxt = CAW_HOLD;
      endcase
      // Status LED pattern by state and remaining time.
      if (st_r == CAW_TRIP)
         led_nxt = blink(ph_r, caw_pkg::TRIP_TICKS);
      else if (st_r == CAW_RUN &&
               wd_r >= 16'(caw_pkg::TIMEOUT_TICKS - caw_pkg::WARN_TICKS))
         led_nxt = blink(ph_r, caw_pkg::WARNB_TICKS);
      else
         led_nxt = blink(ph_r, caw_pkg::ARMED_TICKS);
      // Reset LED latches; the panel reset clears it.
      rled_nxt = rled_r;
      if (!pnl_n_s) rled_nxt = 1'b0;
      if (rst_r) rled_nxt = 1'b1;
      // Over-temperature persistence counter saturates.
      ovt_nxt = ovt ? (ovt_alarm ? ovt_r : (tick_r ? ovt_r + 16'h1 : ovt_r))
                    : 16'h0;
      // Mute holds only while some alarm persists.
      muted_nxt = muted_r;
      if (sil_fall) muted_nxt = 1'b1;
      if (!alarm_any) muted_nxt = 1'b0;
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_r <= 32'h0;
         tick_r <= 1'b0;
         arm_d_r <= 1'b0;
         sil_d_r <= 1'b0;
         st_r <= CAW_HOLD;
         wd_r <= 16'h0;
         ph_r <= 16'h0;
         fph_r <= 16'h0;
         rst_r <= 1'b0;
         rled_r <= 1'b0;
         ovt_r <= 16'h0;
         muted_r <= 1'b0;
         host_restart <= 1'b0;
         wd_relay <= 1'b0;
         module_relay <= 1'b0;
         status_led <= 1'b0;
         reset_led <= 1'b0;
         fan_a_on <= 1'b0;
         fan_b_on <= 1'b0;
         fan_centre_on <= 1'b0;
         temp_led <= 1'b0;
         cpu_fan_led <= 1'b0;
         supply_one_led <= 1'b0;
         supply_two_led <= 1'b0;
         ovt_contact <= 1'b0;
         unlock_contact <= 1'b0;
         unlock_led <= 1'b0;
         buzzer <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         tick_r <= tick_nxt;
         arm_d_r <= arm_d_nxt;
         sil_d_r <= sil_d_nxt;
         st_r <= st_nxt;
         wd_r <= wd_nxt;
         ph_r <= ph_nxt;
         fph_r <= fph_nxt;
         rst_r <= rst_nxt;
         rled_r <= rled_nxt;
         ovt_r <= ovt_nxt;
         muted_r <= muted_nxt;
         host_restart <= rst_nxt;
         wd_relay <= (st_nxt == CAW_TRIP);
         module_relay <= ~maj_s & ~clr_s | ~maj_s;
         status_led <= led_nxt;
         reset_led <= rled_nxt;
         fan_a_on <= 1'b1;
         fan_b_on <= 1'b1;
         fan_centre_on <= ovt;
         temp_led <= ovt;
         cpu_fan_led <= ~fan_bad;
         supply_one_led <= p1_s | blink(fph_r, caw_pkg::FLASH_TICKS);
         supply_two_led <= p2_s | blink(fph_r, caw_pkg::FLASH_TICKS);
         ovt_contact <= ovt_alarm;
         unlock_contact <= ~lock_s ^ jmp_s;
         unlock_led <= ~lock_s;
         buzzer <= alarm_any & ~muted_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence trip_seq;
      st_r == CAW_RUN && !arm_rise &&
         wd_r >= 16'(caw_pkg::TIMEOUT_TICKS);
   endsequence
   AST_TRIP_RESTART: assert property (
      @(posedge clk) disable iff (!reset_n)
      trip_seq |=> host_restart && wd_relay)
      else $error("timeout did not restart host");
   AST_RELAY_TRIP: assert property (
      @(posedge clk) disable iff (!reset_n)
      wd_relay |-> $past(st_nxt) == CAW_TRIP)
      else $error("relay one without trip");
   AST_NO_EARLY: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_r == CAW_HOLD |-> !wd_relay)
      else $error("trip during holdoff");
   AST_HOLD_QUIET: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_r == CAW_HOLD |=> !host_restart)
      else $error("restart during holdoff");
   AST_RLED: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_restart |=> reset_led)
      else $error("reset LED not latched");
   AST_ARM: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_r == CAW_RUN && arm_rise |=> wd_r == 16'h0)
      else $error("arm did not restart count");
   AST_FAN: assert property (
      @(posedge clk) disable iff (!reset_n)
      fan_bad |=> !cpu_fan_led && (buzzer || muted_r))
      else $error("fan failure not flagged");
   AST_MUTE: assert property (
      @(posedge clk) disable iff (!reset_n)
      sil_fall |=> !buzzer)
      else $error("silence ignored");
   AST_UNLOCK: assert property (
      @(posedge clk) disable iff (!reset_n)
      ##1 unlock_led == !$past(lock_s))
      else $error("unlock LED wrong");
   AST_CONTACT: assert property (
      @(posedge clk) disable iff (!reset_n)
      ovt_contact |-> $past(ovt_r) >= 16'(caw_pkg::OVT_TICKS))
      else $error("contact without over-temperature");
   // A lone supply fault must never reach a rear contact.
   AST_SUPPLY_NO_CONTACT: assert property (
      @(posedge clk) disable iff (!reset_n)
      (p1_bad || p2_bad) && !ovt_alarm |=> !ovt_contact)
      else $error("supply fault drove a contact");
   AST_CENTRE_OFF: assert property (
      @(posedge clk) disable iff (!reset_n)
      !ovt |=> !fan_centre_on && fan_a_on && fan_b_on)
      else $error("centre fan on without heat");
   AST_RELAY_TWO: assert property (
      @(posedge clk) disable iff (!reset_n)
      maj_s |=> !module_relay)
      else $error("relay two energised during alarm");
endmodule : caw_top

// [test_caw_top.sv]
// Self-checking bench for the chassis alarm supervisor.
`timescale 1ns/1ns
module test_caw_top;
   localparam int TC = 5;
   logic clk, reset_n, arm_pulse, major_alarm, alarm_clear_req;
   logic panel_reset_n, cpu_fan_under, cpu_fan_over, supply_one_ok;
   logic supply_two_ok, clock_lock_board, unlock_open_jumper, silence_sw;
   logic [7:0] temp_c;
   logic host_restart, wd_relay, module_relay, status_led, reset_led;
   logic fan_a_on, fan_b_on, fan_centre_on, temp_led, cpu_fan_led;
   logic supply_one_led, supply_two_led, ovt_contact, unlock_contact;
   logic unlock_led, buzzer, run, s;
   logic [15:0] period;
   int fails, checks_done, cyc_n, n, p, t0;

   caw_top #(.TICK_CYC(TC)) i_dut (.clk, .reset_n, .arm_pulse,
      .major_alarm, .alarm_clear_req, .panel_reset_n, .temp_c,
      .cpu_fan_under, .cpu_fan_over, .supply_one_ok, .supply_two_ok,
      .clock_lock_board, .unlock_open_jumper, .silence_sw, .host_restart,
      .wd_relay, .module_relay, .status_led, .reset_led, .fan_a_on,
      .fan_b_on, .fan_centre_on, .temp_led, .cpu_fan_led, .supply_one_led,
      .supply_two_led, .ovt_contact, .unlock_contact, .unlock_led, .buzzer);
   caw_host_model i_host (.clk(clk), .run(run), .period(period),
      .arm_pulse(arm_pulse));

   // -----------------------------------------------------------------
   // Clock and cycle count
   // -----------------------------------------------------------------
   // The count starts at reset release so timings are absolute.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_n <= reset_n ? cyc_n + 1 : 0;
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s expected %b seen %b", nm, e, g);
         fails++;
      end
   endtask : chk
   task automatic chkn(input string nm, input int e, input int g);
      checks_done++;
      if (g != e) begin
         $display("unexpected %s expected %0d seen %0d", nm, e, g);
         fails++;
      end
   endtask : chkn
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   // Returns the cycle stamp of the next restart pulse, or -1.
   task automatic wait_restart(input int lim, output int t);
      t = -1;
      for (int i = 0; i < lim && t < 0; i++) begin
         @(negedge clk);
         if (host_restart === 1'b1) t = cyc_n;
      end
   endtask : wait_restart
   task automatic wait_led(input logic v);
      int i;
      i = 0;
      while (status_led !== v && i < 400) begin
         @(negedge clk);
         i++;
      end
      if (i == 400) begin
         chk("status_led_wait", v, status_led);
         results();
      end
   endtask : wait_led
   // Rise-to-rise time of the status LED in clock cycles.
   task automatic led_period(output int q);
      int ts;
      wait_led(1'b0);
      wait_led(1'b1);
      ts = cyc_n;
      wait_led(1'b0);
      wait_led(1'b1);
      q = cyc_n - ts;
   endtask : led_period
   task automatic results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {reset_n, major_alarm, alarm_clear_req, cpu_fan_under} = 4'h0;
      {cpu_fan_over, unlock_open_jumper, silence_sw, run} = 4'h0;
      {panel_reset_n, supply_one_ok, supply_two_ok} = 3'h7;
      clock_lock_board = 1'b1;
      temp_c = 8'h19;
      period = 16'h03e8;
      {fails, checks_done} = 0;
      cyc(5);
      reset_n = 1'b1;
      run = 1'b1; // Arms during holdoff must be ignored.
      cyc(5);
      chk("fan_a_on", 1'b1, fan_a_on);
      chk("fan_b_on", 1'b1, fan_b_on);
      chk("fan_centre_on", 1'b0, fan_centre_on);
      chk("module_relay", 1'b1, module_relay);
      chk("supply_one_led", 1'b1, supply_one_led);
      chk("cpu_fan_led", 1'b1, cpu_fan_led);
      {major_alarm, alarm_clear_req} = 2'h3;
      cyc(5);
      chk("module_relay", 1'b0, module_relay);
      {major_alarm, alarm_clear_req} = 2'h0;
      cyc(5);
      chk("module_relay", 1'b1, module_relay);
      cpu_fan_under = 1'b1;
      cyc(5);
      chk("cpu_fan_led", 1'b0, cpu_fan_led);
      chk("buzzer", 1'b1, buzzer);
      cpu_fan_under = 1'b0;
      cpu_fan_over = 1'b1;
      cyc(5);
      chk("cpu_fan_led", 1'b0, cpu_fan_led);
      cpu_fan_over = 1'b0;
      cyc(5);
      chk("buzzer", 1'b0, buzzer);
      supply_two_ok = 1'b0;
      cyc(5);
      chk("buzzer", 1'b1, buzzer);
      chk("ovt_contact", 1'b0, ovt_contact);
      chk("unlock_contact", 1'b0, unlock_contact);
      chk("module_relay", 1'b1, module_relay);
      s = supply_two_led;
      cyc(caw_pkg::FLASH_TICKS * TC / 2);
      chk("supply_two_led", ~s, supply_two_led);
      chk("supply_one_led", 1'b1, supply_one_led);
      silence_sw = 1'b1;
      cyc(5);
      silence_sw = 1'b0;
      cyc(5);
      chk("buzzer", 1'b0, buzzer);
      supply_two_ok = 1'b1;
      clock_lock_board = 1'b0;
      cyc(5);
      chk("supply_two_led", 1'b1, supply_two_led);
      chk("unlock_led", 1'b1, unlock_led);
      chk("unlock_contact", 1'b1, unlock_contact);
      unlock_open_jumper = 1'b1;
      cyc(5);
      chk("unlock_contact", 1'b0, unlock_contact);
      {clock_lock_board, unlock_open_jumper} = 2'h2;
      temp_c = 8'h29;
      cyc(5);
      chk("unlock_led", 1'b0, unlock_led);
      chk("fan_centre_on", 1'b1, fan_centre_on);
      chk("temp_led", 1'b1, temp_led);
      temp_c = 8'h28;
      cyc(5);
      chk("fan_centre_on", 1'b0, fan_centre_on);
      run = 1'b0;
      wait_restart(18000, n);
      chkn("restart_cycle", 17000, (n > 16980 && n < 17040) ? 17000 : n);
      if (n < 0) results();
      cyc(5);
      chk("wd_relay", 1'b1, wd_relay);
      chk("reset_led", 1'b1, reset_led);
      led_period(p);
      chkn("trip_period", caw_pkg::TRIP_TICKS * TC, p);
      panel_reset_n = 1'b0;
      cyc(5);
      panel_reset_n = 1'b1;
      cyc(5);
      chk("reset_led", 1'b0, reset_led);
      run = 1'b1;
      cyc(60);
      chk("wd_relay", 1'b0, wd_relay);
      led_period(p);
      chkn("armed_period", caw_pkg::ARMED_TICKS * TC, p);
      wait_restart(5000, n);
      chkn("restart_while_armed", -1, n);
      run = 1'b0;
      cyc(5);
      run = 1'b1;
      t0 = cyc_n;
      cyc(3);
      run = 1'b0;
      cyc(1200);
      led_period(p);
      chkn("warn_period", caw_pkg::WARNB_TICKS * TC, p);
      wait_restart(1000, n);
      if (n < 0) begin
         chkn("restart_after_arm", 0, n);
         results();
      end
      n = n - t0 - caw_pkg::TIMEOUT_TICKS * TC;
      chkn("restart_after_arm", 0, (n > -5 && n < 30) ? 0 : n);
      run = 1'b1;
      temp_c = 8'h2d;
      cyc(caw_pkg::OVT_TICKS * TC - 100);
      chk("buzzer", 1'b0, buzzer);
      chk("ovt_contact", 1'b0, ovt_contact);
      cyc(200);
      chk("buzzer", 1'b1, buzzer);
      chk("ovt_contact", 1'b1, ovt_contact);
      silence_sw = 1'b1;
      cyc(5);
      silence_sw = 1'b0;
      cyc(5);
      chk("buzzer", 1'b0, buzzer);
      chk("temp_led", 1'b1, temp_led);
      temp_c = 8'h19;
      cyc(5);
      chk("ovt_contact", 1'b0, ovt_contact);
      results();
   end
endmodule : test_caw_top
